// file: verilog/csst_pkg.sv
/*
 * constants for the clock source select, start-up timer and rc trim block.
 * assumes fuse values arrive raw, 0 meaning programmed.
 */
package csst_pkg;
  // clock source fuse patterns
  localparam logic [3:0] SRC_RC4_A = 4'h2;
  localparam logic [3:0] SRC_RC4_B = 4'h3;
  localparam logic [3:0] SRC_RC8_A = 4'h4;
  localparam logic [3:0] SRC_RC8_B = 4'h5;
  localparam logic [2:0] BAND_LO = 3'h4;
  localparam logic [2:0] BAND_MID = 3'h5;
  localparam logic [2:0] BAND_HI = 3'h6;
  localparam logic [2:0] BAND_TOP = 3'h7;
  localparam logic [1:0] SUT_0 = 2'h0;
  localparam logic [1:0] SUT_1 = 2'h1;
  localparam logic [1:0] SUT_2 = 2'h2;
  localparam logic [1:0] SUT_3 = 2'h3;
  localparam logic FUSE_PROG = 1'b0;
  // oscillator cycle counts on wake-up, plus the extra count added after reset only
  localparam int CK_SHORT = 258;
  localparam int CK_MID = 1024;
  localparam int CK_RC = 6;
  localparam int CK_RST_EXTRA = 14;
  // watchdog oscillator cycles for the reset time-out
  localparam int WDT_SHORT = 512;
  // prescaler reset values
  localparam logic [3:0] PS_DIV8 = 4'h3;
  localparam logic [3:0] PS_DIV1 = 4'h0;
  // trim register and start-up counter widths
  localparam int TRIM_W = 7;
  localparam int CNT_W = 20;
  typedef enum logic [1:0] {
    XB_LO,
    XB_MID,
    XB_HI,
    XB_TOP
  } csst_band_t;
  typedef enum {
    ST_WDT,
    ST_OSC,
    ST_RUN,
    ST_SLEEP
  } csst_state_t;
endpackage

// file: verilog/csst_clock_ctrl.sv
/*
 * clock source decode, start-up timing, prescaler reset value and rc trim.
 * assumes i_osc_tick pulses once per selected oscillator cycle and
 * i_wdt_tick once per watchdog oscillator cycle, both synchronous to mclk.
 */
`timescale 1ns/1ps
module csst_clock_ctrl #(
  parameter int CK_LONG = 16384,
  parameter int WDT_LONG = 8192
) (
  input wire logic I_MCLK,
  input wire logic I_SYS_RST,
  input wire logic [3:0] I_CLOCK_SOURCE_FUSES,
  input wire logic [1:0] I_STARTUP_TIME_FIELD,
  input wire logic I_DIV_BY_EIGHT_FUSE,
  input wire logic [6:0] I_FACTORY_CAL,
  input wire logic I_OSC_TICK,
  input wire logic I_WDT_TICK,
  input wire logic I_SLEEP_REQ,
  input wire logic I_WAKE_REQ,
  input wire logic I_TRIM_WE,
  input wire logic [7:0] I_TRIM_WDATA,
  output logic [7:0] O_TRIM_RDATA,
  output logic [6:0] O_RC_TRIM,
  output logic O_RC_SEL,
  output logic O_RC_8M,
  output logic O_XTAL_EN,
  output logic [1:0] O_XTAL_BAND,
  output logic O_CFG_RESERVED,
  output logic [3:0] O_PRESCALE_SELECT,
  output logic O_CLK_RUN,
  output logic O_NVM_RC_TIMEBASE
);

  typedef struct packed {
    csst_pkg::csst_state_t st;
    logic [csst_pkg::CNT_W-1:0] cnt;
    logic [csst_pkg::TRIM_W-1:0] trim;
    logic [3:0] ps;
    logic run;
    logic rc_sel;
    logic rc_8m;
    logic xtal_en;
    logic [1:0] band;
    logic rsvd;
  } csst_regs_t;

  csst_regs_t r_reg;
  csst_regs_t r_next;

  ////////////////////////////////////////////////////////////////////////////
  // fuse decode

  // wake-up oscillator cycles for the current fuse setting
  function automatic logic [csst_pkg::CNT_W-1:0] wake_ck(
    input logic [3:0] src, input logic [1:0] sut);
    logic [csst_pkg::CNT_W-1:0] n;
    n = csst_pkg::CNT_W'(csst_pkg::CK_RC);
    if (src[3]) begin
      if (!src[0] && (sut == csst_pkg::SUT_0 || sut == csst_pkg::SUT_1)) begin
        n = csst_pkg::CNT_W'(csst_pkg::CK_SHORT);
      end else if (src[0] && sut != csst_pkg::SUT_0) begin
        n = csst_pkg::CNT_W'(CK_LONG);
      end else begin
        n = csst_pkg::CNT_W'(csst_pkg::CK_MID);
      end
    end
    return n;
  endfunction

  // watchdog cycles added after reset; 0, short or long
  function automatic logic [csst_pkg::CNT_W-1:0] rst_wdt(
    input logic [3:0] src, input logic [1:0] sut);
    logic [1:0] k;
    k = 2'h2;
    if (src[3]) begin
      unique case ({src[0], sut})
        {1'b0, csst_pkg::SUT_0}: k = 2'h1;
        {1'b0, csst_pkg::SUT_1}: k = 2'h2;
        {1'b0, csst_pkg::SUT_2}: k = 2'h0;
        {1'b0, csst_pkg::SUT_3}: k = 2'h1;
        {1'b1, csst_pkg::SUT_0}: k = 2'h2;
        {1'b1, csst_pkg::SUT_1}: k = 2'h0;
        {1'b1, csst_pkg::SUT_2}: k = 2'h1;
        {1'b1, csst_pkg::SUT_3}: k = 2'h2;
      endcase
    end else if (sut != csst_pkg::SUT_3) begin
      k = sut;
    end
    unique case (k)
      2'h0: return '0;
      2'h1: return csst_pkg::CNT_W'(csst_pkg::WDT_SHORT);
      default: return csst_pkg::CNT_W'(WDT_LONG);
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // next state

  logic [3:0] src;
  logic [1:0] sut;
  logic is_rc;
  logic is_rc8;
  assign src = I_CLOCK_SOURCE_FUSES;
  assign sut = I_STARTUP_TIME_FIELD;
  assign is_rc8 = src == csst_pkg::SRC_RC8_A || src == csst_pkg::SRC_RC8_B;
  assign is_rc = is_rc8 || src == csst_pkg::SRC_RC4_A ||
                 src == csst_pkg::SRC_RC4_B;

  always_comb begin
    r_next = r_reg;
    r_next.rc_sel = is_rc;
    r_next.rc_8m = is_rc8;
    r_next.xtal_en = src[3];
    unique case (src[3:1])
      csst_pkg::BAND_LO: r_next.band = csst_pkg::XB_LO;
      csst_pkg::BAND_MID: r_next.band = csst_pkg::XB_MID;
      csst_pkg::BAND_HI: r_next.band = csst_pkg::XB_HI;
      csst_pkg::BAND_TOP: r_next.band = csst_pkg::XB_TOP;
      default: r_next.band = csst_pkg::XB_LO;
    endcase
    // unsupported sources fall back to the rc timing table
    r_next.rsvd = (!src[3] && !is_rc) || (is_rc && sut == csst_pkg::SUT_3);
    // bit 7 is not stored and reads as zero
    if (I_TRIM_WE) begin
      r_next.trim = I_TRIM_WDATA[csst_pkg::TRIM_W-1:0];
    end
    unique case (r_reg.st)
      csst_pkg::ST_WDT: begin
        if (r_reg.cnt == '0) begin
          r_next.st = csst_pkg::ST_OSC;
          r_next.cnt = wake_ck(src, sut) +
                       csst_pkg::CNT_W'(csst_pkg::CK_RST_EXTRA);
        end else if (I_WDT_TICK) begin
          r_next.cnt = r_reg.cnt - 1'b1;
        end
      end
      csst_pkg::ST_OSC: begin
        if (I_OSC_TICK) begin
          if (r_reg.cnt <= csst_pkg::CNT_W'(1)) begin
            r_next.st = csst_pkg::ST_RUN;
            r_next.run = 1'b1;
          end else begin
            r_next.cnt = r_reg.cnt - 1'b1;
          end
        end
      end
      csst_pkg::ST_RUN: begin
        if (I_SLEEP_REQ) begin
          r_next.st = csst_pkg::ST_SLEEP;
          r_next.run = 1'b0;
        end
      end
      csst_pkg::ST_SLEEP: begin
        if (I_WAKE_REQ) begin
          r_next.st = csst_pkg::ST_OSC;
          r_next.cnt = wake_ck(src, sut);
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge I_MCLK) begin
    if (I_SYS_RST) begin
      r_reg <= '0;
      r_reg.st <= csst_pkg::ST_WDT;
      r_reg.cnt <= rst_wdt(src, sut);
      r_reg.trim <= I_FACTORY_CAL;
      r_reg.ps <= (I_DIV_BY_EIGHT_FUSE == csst_pkg::FUSE_PROG) ?
                  csst_pkg::PS_DIV8 : csst_pkg::PS_DIV1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign O_TRIM_RDATA = {1'b0, r_reg.trim};
  // trim drives the rc oscillator span
  assign O_RC_TRIM = r_reg.trim;
  assign O_RC_SEL = r_reg.rc_sel;
  assign O_RC_8M = r_reg.rc_8m;
  assign O_XTAL_EN = r_reg.xtal_en;
  assign O_XTAL_BAND = r_reg.band;
  assign O_CFG_RESERVED = r_reg.rsvd;
  assign O_PRESCALE_SELECT = r_reg.ps;
  assign O_CLK_RUN = r_reg.run;
  // memory timing always follows the trimmed rc
  assign O_NVM_RC_TIMEBASE = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  // reset level as antecedent: no sampled history needed before time zero
  trim_load_a: assert property (@(posedge I_MCLK)
    I_SYS_RST |=> O_RC_TRIM == $past(I_FACTORY_CAL))
    else $error("trim not loaded at reset");
  trim_write_a: assert property (@(posedge I_MCLK)
    disable iff (I_SYS_RST)
    I_TRIM_WE |=> O_TRIM_RDATA == {1'b0, $past(I_TRIM_WDATA[6:0])})
    else $error("trim write lost");
  ps_reset_a: assert property (@(posedge I_MCLK)
    I_SYS_RST |=> O_PRESCALE_SELECT ==
      (($past(I_DIV_BY_EIGHT_FUSE) == csst_pkg::FUSE_PROG) ?
       csst_pkg::PS_DIV8 : csst_pkg::PS_DIV1))
    else $error("prescaler reset value wrong");
  gate_hold_a: assert property (@(posedge I_MCLK)
    disable iff (I_SYS_RST)
    O_CLK_RUN |-> r_reg.st == csst_pkg::ST_RUN)
    else $error("clock ran during start-up");
  reset_gate_a: assert property (@(posedge I_MCLK)
    I_SYS_RST |=> !O_CLK_RUN [*2])
    else $error("clock not gated after reset");
  rc_decode_a: assert property (@(posedge I_MCLK)
    disable iff (I_SYS_RST)
    $stable(I_CLOCK_SOURCE_FUSES) && I_CLOCK_SOURCE_FUSES[3:1] == 3'h2
    |=> O_RC_SEL && O_RC_8M)
    else $error("rc 8 MHz not selected");
  band_decode_a: assert property (@(posedge I_MCLK)
    disable iff (I_SYS_RST)
    I_CLOCK_SOURCE_FUSES[3] |=> O_XTAL_EN &&
      O_XTAL_BAND == $past(I_CLOCK_SOURCE_FUSES[2:1]))
    else $error("crystal band wrong");
  rc_wake_a: assert property (@(posedge I_MCLK)
    disable iff (I_SYS_RST)
    r_reg.st == csst_pkg::ST_SLEEP && I_WAKE_REQ && is_rc
    |=> r_reg.cnt == 20'h00006)
    else $error("rc wake count wrong");
  xtal_wake_a: assert property (@(posedge I_MCLK)
    disable iff (I_SYS_RST)
    r_reg.st == csst_pkg::ST_SLEEP && I_WAKE_REQ && src[3] && !src[0] &&
    !sut[1] |=> r_reg.cnt == 20'h00102)
    else $error("258 cycle wake wrong");
  sleep_gate_a: assert property (@(posedge I_MCLK)
    disable iff (I_SYS_RST)
    O_CLK_RUN && I_SLEEP_REQ |=> !O_CLK_RUN)
    else $error("clock not stopped on sleep");

endmodule

// file: sim/csst_osc_model.sv
/*
 * resonator and watchdog oscillator model: tick pulses for the block.
 * assumes ticks are sampled on the rising edge of i_clk.
 */
`timescale 1ns/1ps
module csst_osc_model (
  input wire logic i_clk,
  output logic o_osc_tick,
  output logic o_wdt_tick
);
  logic [1:0] wdt_div_reg = 2'h0;
  initial o_osc_tick = 1'b0;
  initial o_wdt_tick = 1'b0;
  //////////////////////////////////////////////////////////////////////////
  // both ticks divided down from the falling edge of i_clk
  // uneven ratio so a swapped tick source shows up in the counts
  always @(negedge i_clk) begin
    o_osc_tick <= ~o_osc_tick;
    wdt_div_reg <= (wdt_div_reg == 2'h2) ? 2'h0 : wdt_div_reg + 2'h1;
    o_wdt_tick <= (wdt_div_reg == 2'h2);
  end
endmodule

// file: sim/tb.sv
/*
 * self-checking bench: reset start-up, wake timing, decode and trim.
 * assumes the oscillator model ticks run freely from time zero.
 */
`timescale 1ns/1ps
module tb;
  localparam int CKL = 40;
  localparam int WDL = 30;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] src = 4'h4;
  logic [1:0] sut = 2'h2;
  logic div8 = 1'b0;
  logic [6:0] cal = 7'h55;
  logic slp = 1'b0;
  logic wak = 1'b0;
  logic we = 1'b0;
  logic [7:0] wd = 8'h00;
  logic osc_tick, wdt_tick, rc_sel, rc_8m, xen, cres, run, nvm;
  logic [7:0] rd;
  logic [6:0] trim;
  logic [1:0] band;
  logic [3:0] ps;
  int mismatches = 0;
  int checked = 0;
  always #5 clk = ~clk;
  csst_osc_model csst_osc_model_inst (.i_clk(clk), .o_osc_tick(osc_tick),
    .o_wdt_tick(wdt_tick));
  csst_clock_ctrl #(.CK_LONG(CKL), .WDT_LONG(WDL)) csst_clock_ctrl_inst (
    .I_MCLK(clk), .I_SYS_RST(rst), .I_CLOCK_SOURCE_FUSES(src),
    .I_STARTUP_TIME_FIELD(sut), .I_DIV_BY_EIGHT_FUSE(div8),
    .I_FACTORY_CAL(cal), .I_OSC_TICK(osc_tick), .I_WDT_TICK(wdt_tick),
    .I_SLEEP_REQ(slp), .I_WAKE_REQ(wak), .I_TRIM_WE(we),
    .I_TRIM_WDATA(wd), .O_TRIM_RDATA(rd), .O_RC_TRIM(trim),
    .O_RC_SEL(rc_sel), .O_RC_8M(rc_8m), .O_XTAL_EN(xen),
    .O_XTAL_BAND(band), .O_CFG_RESERVED(cres), .O_PRESCALE_SELECT(ps),
    .O_CLK_RUN(run), .O_NVM_RC_TIMEBASE(nvm));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("mismatches=%0d checked=%0d", mismatches, checked);
    if (mismatches == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // counts ticks while the clocks stay gated; the load cycle may eat one
  task automatic wait_run(input int wdt_need, input int osc_need);
    int w, o, k;
    w = 0;
    o = 0;
    for (k = 0; k < 20000 && run !== 1'b1; k++) begin
      @(posedge clk);
      #1;
      if (osc_tick === 1'b1 && w >= wdt_need) o++;
      if (wdt_tick === 1'b1) w++;
    end
    if (k >= 20000) begin
      mismatches++;
      report_and_stop();
    end else begin
      check(w >= wdt_need && o >= osc_need && o <= osc_need + 1, 1);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset(input logic [3:0] s, input logic [1:0] f,
      input logic d, input int wdt_need, input int osc_need);
    // the opening reset is already high from time zero
    if (rst !== 1'b1) @(negedge clk);
    src = s;
    sut = f;
    div8 = d;
    rst = 1'b1;
    repeat (12) @(negedge clk);
    check(rd, {1'b0, cal});
    check(trim, cal);
    check(ps, d ? csst_pkg::PS_DIV1 : csst_pkg::PS_DIV8);
    check(run, 1'b0);
    rst = 1'b0;
    wait_run(wdt_need, osc_need);
    check(rc_sel, !s[3]);
    check(rc_8m, s[2] && !s[3]);
    check(nvm, 1'b1);
  endtask
  task automatic t_decode;
    int s;
    for (s = 0; s < 16; s++) begin
      @(negedge clk);
      src = 4'(s);
      sut = 2'h0;
      repeat (2) @(negedge clk);
      check(rc_sel, s >= 2 && s <= 5);
      check(rc_8m, s == 4 || s == 5);
      check(xen, s >= 8);
      check(cres, s < 2 || s == 6 || s == 7);
      if (s >= 8) check(band, s[2:1]);
    end
    src = 4'h4;
    sut = 2'h3;
    repeat (2) @(negedge clk);
    check(cres, 1'b1);
    sut = 2'h2;
  endtask
  task automatic t_trim;
    @(negedge clk);
    // steps of at most 0x20 from 0x2a
    we = 1'b1;
    wd = 8'hc0;
    @(negedge clk);
    check(rd, 8'h40);
    wd = 8'h5f;
    @(negedge clk);
    check(rd, 8'h5f);
    wd = 8'h7f;
    @(negedge clk);
    we = 1'b0;
    check(trim, 7'h7f);
  endtask
  task automatic t_wake(input logic [3:0] s, input logic [1:0] f,
      input int need);
    @(negedge clk);
    src = s;
    sut = f;
    repeat (2) @(negedge clk);
    slp = 1'b1;
    @(negedge clk);
    slp = 1'b0;
    check(run, 1'b0);
    wak = 1'b1;
    @(negedge clk);
    wak = 1'b0;
    wait_run(0, need);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    // divide fuse programmed with the 8 MHz rc source
    t_reset(4'h4, 2'h2, 1'b0, WDL, 6 + 14);
    t_decode();
    cal = 7'h2a;
    t_reset(4'h2, 2'h0, 1'b1, 0, 6 + 14);
    t_trim();
    // lowest band driven as a ceramic resonator only
    t_wake(4'h8, 2'h0, 258);
    t_wake(4'hc, 2'h2, 1024);
    t_wake(4'hf, 2'h0, 1024);
    t_wake(4'hd, 2'h1, CKL);
    t_wake(4'h4, 2'h0, 6);
    t_reset(4'hf, 2'h3, 1'b1, WDL, CKL + 14);
    t_reset(4'h3, 2'h1, 1'b0, 512, 6 + 14);
    report_and_stop();
  end
endmodule
